/* verilog/mem_decode_regs.svh */
// address map constants for the memory decoder
// Notes on behaviour
// R1 - program and data spaces decode independently; same address may hit different storage.
// R2 - program fetches 0x0000 to 0x3FFF go to the on-chip flash.
// R3 - after any reset the first fetch address is 0x0000.
// R4 - external data RAM 0x0000 to 0x02FF, reached only by the external data move.
// R5 - internal 0x00 to 0x1F are four banks of eight registers.
// R6 - internal 0x20 to 0x2F are also bit addressable.
// R7 - internal 0x30 to 0x7F are plain RAM, direct and indirect.
// R8 - indirect access to 0x80 to 0xFF goes to upper internal RAM.
// R9 - direct access to 0x80 to 0xFF goes to special function registers.
// R10 - stack push and pop address internal RAM only.
// R11 - bit access to function registers only where address low nibble is 0 or 8.
// R12 - software avoids read-modify-write on registers whose read differs from write.
// R13 - function registers split between direct space and an external window.
// R14 - exactly one target per access; unmapped data reads return zero.
`ifndef MEM_DECODE_REGS_SVH
`define MEM_DECODE_REGS_SVH
`define PROG_FLASH_LAST 16'h3FFF
`define PROG_RESET_ADDR 16'h0000
`define XDATA_RAM_LAST 16'h02FF
`define XWIN_LOW_FIRST 16'h0300
`define XWIN_LOW_LAST 16'h03FF
`define XWIN_HIGH_FIRST 16'h4018
`define XWIN_HIGH_LAST 16'h40FF
`define IDATA_BANK_LAST 8'h1F
`define IDATA_BIT_FIRST 8'h20
`define IDATA_BIT_LAST 8'h2F
`define IDATA_UPPER_FIRST 8'h80
`define BANK_SEL_LSB 3
`endif

/* verilog/mem_decode_pkg.sv */
// types for the memory decoder
`default_nettype none
package mem_decode_pkg;
  typedef enum logic [2:0] {
    acc_none,
    acc_direct,
    acc_indirect,
    acc_bit,
    acc_stack,
    acc_xmove
  } access_e;

  typedef enum logic [3:0] {
    tgt_none,
    tgt_bank,
    tgt_bitram,
    tgt_lowram,
    tgt_upram,
    tgt_sfr,
    tgt_external_data_ram,
    tgt_xwin,
    tgt_flash
  } target_e;

  typedef struct packed {
    logic valid;
    access_e kind;
    logic [15:0] addr;
    logic [2:0] bit_pos;
  } data_req_s;

  typedef struct packed {
    target_e target;
    logic [15:0] offset;
    logic [2:0] bit_pos;
    logic bit_op;
  } data_sel_s;
endpackage
`default_nettype wire

/* verilog/data_space_decode.sv */
// combinational decode of one data space access
`timescale 1ns/1ps
`default_nettype none
`include "mem_decode_regs.svh"
module data_space_decode
(
  // request
  input wire mem_decode_pkg::data_req_s req,
  // decoded select
  output var mem_decode_pkg::data_sel_s sel
);
  logic [7:0] ia;
  logic [7:0] bit_byte;

  always_comb
  begin
    ia = req.addr[7:0];
    bit_byte = 8'h00;
    sel.target = mem_decode_pkg::tgt_none;
    sel.offset = 16'h0000;
    sel.bit_pos = req.bit_pos;
    sel.bit_op = 1'b0;
    if (req.valid)
    begin
      unique case (req.kind)
        mem_decode_pkg::acc_xmove:
        begin
          // external space only by the move instruction
          if (req.addr <= `XDATA_RAM_LAST) // R4
          begin
            sel.target = mem_decode_pkg::tgt_external_data_ram;
            sel.offset = req.addr;
          end
          else if ((req.addr >= `XWIN_LOW_FIRST && req.addr <= `XWIN_LOW_LAST) ||
                   (req.addr >= `XWIN_HIGH_FIRST && req.addr <= `XWIN_HIGH_LAST)) // R13
          begin
            sel.target = mem_decode_pkg::tgt_xwin;
            sel.offset = req.addr;
          end
        end
        mem_decode_pkg::acc_direct, mem_decode_pkg::acc_indirect, mem_decode_pkg::acc_stack:
        begin
          sel.offset = {8'h00, ia};
          if (ia <= `IDATA_BANK_LAST) // R5
            sel.target = mem_decode_pkg::tgt_bank;
          else if (ia <= `IDATA_BIT_LAST) // R6
            sel.target = mem_decode_pkg::tgt_bitram;
          else if (ia < `IDATA_UPPER_FIRST) // R7
            sel.target = mem_decode_pkg::tgt_lowram;
          else if (req.kind == mem_decode_pkg::acc_direct) // R9
            sel.target = mem_decode_pkg::tgt_sfr;
          else // R8 R10
            sel.target = mem_decode_pkg::tgt_upram;
        end
        mem_decode_pkg::acc_bit:
        begin
          // bit address below 0x80 lands in 0x20..0x2F
          sel.bit_op = 1'b1;
          sel.bit_pos = ia[2:0];
          if (!ia[7])
          begin
            bit_byte = `IDATA_BIT_FIRST + {4'h0, ia[6:3]}; // R6
            sel.target = mem_decode_pkg::tgt_bitram;
            sel.offset = {8'h00, bit_byte};
          end
          else
          begin
            bit_byte = {ia[7:3], 3'h0}; // R11
            sel.target = mem_decode_pkg::tgt_sfr;
            sel.offset = {8'h00, bit_byte};
          end
        end
        default:
          sel.target = mem_decode_pkg::tgt_none;
      endcase
    end
  end
endmodule
`default_nettype wire

/* verilog/memory_address_decoder.sv */
// program and data space address decoder with registered selects
`timescale 1ns/1ps
`default_nettype none
`include "mem_decode_regs.svh"
module memory_address_decoder
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // program fetch
  input wire logic fetch_req,
  input wire logic [15:0] fetch_addr,
  output logic [15:0] fetch_pc,
  output logic flash_sel,
  output logic [13:0] flash_addr,
  output logic fetch_fault,
  // data access
  input wire mem_decode_pkg::data_req_s data_req,
  input wire logic [7:0] psw_bank,
  output var mem_decode_pkg::data_sel_s data_sel,
  output logic unmapped,
  // read data
  input wire logic [7:0] target_rdata,
  output logic [7:0] read_data
);
  mem_decode_pkg::data_sel_s comb_sel;
  mem_decode_pkg::data_req_s req_adj;
  logic [15:0] pc_ff;
  logic [15:0] nxt_pc;
  logic flash_sel_ff;
  logic nxt_flash_sel;
  logic [13:0] flash_addr_ff;
  logic [13:0] nxt_flash_addr;
  logic fault_ff;
  logic nxt_fault;
  mem_decode_pkg::data_sel_s sel_ff;
  mem_decode_pkg::data_sel_s nxt_sel;
  logic unmapped_ff;
  logic nxt_unmapped;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // internal kinds ignore the upper address byte
  always_comb
  begin
    req_adj = data_req;
    req_adj.addr[15:8] = (data_req.kind == mem_decode_pkg::acc_xmove) ? data_req.addr[15:8] : 8'h00; // R1
  end

  data_space_decode u_data
  (
    .req(req_adj),
    .sel(comb_sel)
  );

  // program space
  always_comb
  begin
    nxt_pc = pc_ff;
    nxt_flash_sel = 1'b0;
    nxt_flash_addr = flash_addr_ff;
    nxt_fault = 1'b0;
    if (rst)
    begin
      nxt_pc = `PROG_RESET_ADDR; // R3
      nxt_flash_addr = 14'h0000;
    end
    else if (fetch_req)
    begin
      nxt_pc = fetch_addr;
      if (fetch_addr <= `PROG_FLASH_LAST) // R2
      begin
        nxt_flash_sel = 1'b1;
        nxt_flash_addr = fetch_addr[13:0];
      end
      else
        nxt_fault = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    pc_ff <= nxt_pc;
    flash_sel_ff <= nxt_flash_sel;
    flash_addr_ff <= nxt_flash_addr;
    fault_ff <= nxt_fault;
  end

  // data space
  always_comb
  begin
    nxt_sel = comb_sel;
    nxt_unmapped = data_req.valid && comb_sel.target == mem_decode_pkg::tgt_none; // R14
    nxt_rdata = 8'h00;
    if (rst)
    begin
      nxt_sel.target = mem_decode_pkg::tgt_none;
      nxt_sel.offset = 16'h0000;
      nxt_sel.bit_pos = 3'h0;
      nxt_sel.bit_op = 1'b0;
      nxt_unmapped = 1'b0;
    end
    else if (sel_ff.target != mem_decode_pkg::tgt_none)
      nxt_rdata = target_rdata; // R14
  end

  always_ff @(posedge clock)
  begin
    sel_ff <= nxt_sel;
    unmapped_ff <= nxt_unmapped;
    rdata_ff <= nxt_rdata;
  end

  assign fetch_pc = pc_ff;
  assign flash_sel = flash_sel_ff;
  assign flash_addr = flash_addr_ff;
  assign fetch_fault = fault_ff;
  assign data_sel = sel_ff;
  assign unmapped = unmapped_ff;
  assign read_data = rdata_ff;

  a_reset_pc: assert property (@(posedge clock) rst |=> fetch_pc == `PROG_RESET_ADDR && !flash_sel) // R3
    else $error("fetch address not zero after reset");
  a_flash_range: assert property (@(posedge clock) disable iff (rst) // R2
    fetch_req && fetch_addr <= `PROG_FLASH_LAST |=> flash_sel && flash_addr == $past(fetch_addr[13:0]))
    else $error("flash fetch not selected");
  a_flash_beyond: assert property (@(posedge clock) disable iff (rst) // R2
    fetch_req && fetch_addr > `PROG_FLASH_LAST |=> !flash_sel && fetch_fault)
    else $error("fetch beyond flash selected");
  a_external_data_ram_only_move: assert property (@(posedge clock) disable iff (rst) // R4
    data_sel.target == mem_decode_pkg::tgt_external_data_ram |-> $past(data_req.kind) == mem_decode_pkg::acc_xmove)
    else $error("external ram reached without move");
  a_external_data_ram_range: assert property (@(posedge clock) disable iff (rst) // R4
    data_req.valid && data_req.kind == mem_decode_pkg::acc_xmove && data_req.addr <= `XDATA_RAM_LAST
    |=> data_sel.target == mem_decode_pkg::tgt_external_data_ram)
    else $error("external ram not selected");
  a_xwin_range: assert property (@(posedge clock) disable iff (rst) // R13
    data_req.valid && data_req.kind == mem_decode_pkg::acc_xmove &&
    data_req.addr >= `XWIN_LOW_FIRST && data_req.addr <= `XWIN_LOW_LAST
    |=> data_sel.target == mem_decode_pkg::tgt_xwin)
    else $error("external register window not selected");
  a_bank_range: assert property (@(posedge clock) disable iff (rst) // R5
    data_req.valid && data_req.kind == mem_decode_pkg::acc_indirect && data_req.addr[7:0] <= `IDATA_BANK_LAST
    |=> data_sel.target == mem_decode_pkg::tgt_bank)
    else $error("bank registers not selected");
  a_bit_area: assert property (@(posedge clock) disable iff (rst) // R6
    data_req.valid && data_req.kind == mem_decode_pkg::acc_bit && !data_req.addr[7]
    |=> data_sel.target == mem_decode_pkg::tgt_bitram &&
    data_sel.offset[7:0] >= `IDATA_BIT_FIRST && data_sel.offset[7:0] <= `IDATA_BIT_LAST)
    else $error("bit address outside bit area");
  a_low_ram: assert property (@(posedge clock) disable iff (rst) // R7
    data_req.valid && data_req.kind inside {mem_decode_pkg::acc_direct, mem_decode_pkg::acc_indirect} &&
    data_req.addr[7:0] > `IDATA_BIT_LAST && !data_req.addr[7]
    |=> data_sel.target == mem_decode_pkg::tgt_lowram)
    else $error("plain ram not selected");
  a_upper_indirect: assert property (@(posedge clock) disable iff (rst) // R8
    data_req.valid && data_req.kind == mem_decode_pkg::acc_indirect && data_req.addr[7]
    |=> data_sel.target == mem_decode_pkg::tgt_upram)
    else $error("indirect upper not ram");
  a_upper_direct: assert property (@(posedge clock) disable iff (rst) // R9
    data_req.valid && data_req.kind == mem_decode_pkg::acc_direct && data_req.addr[7]
    |=> data_sel.target == mem_decode_pkg::tgt_sfr)
    else $error("direct upper not function register");
  a_stack_internal: assert property (@(posedge clock) disable iff (rst) // R10
    data_req.valid && data_req.kind == mem_decode_pkg::acc_stack
    |=> data_sel.target != mem_decode_pkg::tgt_external_data_ram && data_sel.target != mem_decode_pkg::tgt_xwin)
    else $error("stack left internal ram");
  a_bit_sfr: assert property (@(posedge clock) disable iff (rst) // R11
    data_sel.bit_op && data_sel.target == mem_decode_pkg::tgt_sfr |-> data_sel.offset[2:0] == 3'h0)
    else $error("bit access to unaligned register");
  a_internal_upper: assert property (@(posedge clock) disable iff (rst) // R1
    data_sel.target inside {mem_decode_pkg::tgt_bank, mem_decode_pkg::tgt_bitram, mem_decode_pkg::tgt_lowram,
    mem_decode_pkg::tgt_upram, mem_decode_pkg::tgt_sfr} |-> data_sel.offset[15:8] == 8'h00)
    else $error("internal select carries upper address");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (rst) // R14
    unmapped |=> read_data == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* verif/target_store_model.sv */
// storage model that answers the decoder's data selects
`timescale 1ns/1ps
`default_nettype none
module target_store_model
(
  // decoded select
  input wire mem_decode_pkg::data_sel_s sel,
  // read data back to the decoder
  output logic [7:0] rdata
);
  // nonzero when nothing is selected, so a zero must come from the decoder
  always_comb
  begin
    if (sel.target != mem_decode_pkg::tgt_none)
      rdata = sel.offset[7:0] ^ 8'hA5;
    else
      rdata = 8'hC3;
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the memory address decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock;
  logic rst;
  logic fetch_req;
  logic [15:0] fetch_addr;
  logic [15:0] fetch_pc;
  logic flash_sel;
  logic [13:0] flash_addr;
  logic fetch_fault;
  mem_decode_pkg::data_req_s data_req;
  mem_decode_pkg::data_sel_s data_sel;
  logic unmapped;
  logic [7:0] target_rdata;
  logic [7:0] read_data;
  int n_mismatch;
  int n_tests;
  int cycles;
  memory_address_decoder dut_u (.clock(clock), .rst(rst), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_pc(fetch_pc), .flash_sel(flash_sel), .flash_addr(flash_addr), .fetch_fault(fetch_fault),
    .data_req(data_req), .psw_bank(8'h00), .data_sel(data_sel), .unmapped(unmapped),
    .target_rdata(target_rdata), .read_data(read_data));
  target_store_model model_u (.sel(data_sel), .rdata(target_rdata));
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one data access; off of FFFF means the offset is not checked
  task automatic dreq(input mem_decode_pkg::access_e k, input logic [15:0] a, input logic [2:0] bp,
    input mem_decode_pkg::target_e t, input logic [15:0] off);
    data_req = '{valid: 1'b1, kind: k, addr: a, bit_pos: bp};
    @(posedge clock);
    #1;
    data_req.valid = 1'b0;
    chk(data_sel.target, t);
    chk(unmapped, t == mem_decode_pkg::tgt_none);
    chk(data_sel.bit_op, k == mem_decode_pkg::acc_bit);
    if (k == mem_decode_pkg::acc_bit)
      chk(data_sel.bit_pos, bp);
    if (off != 16'hFFFF)
      chk(data_sel.offset, off);
    @(posedge clock);
    #1;
    if (t == mem_decode_pkg::tgt_none)
      chk(read_data, 8'h00);
    else if (off != 16'hFFFF)
      chk(read_data, off[7:0] ^ 8'hA5);
  endtask
  task automatic freq(input logic [15:0] a);
    fetch_req = 1'b1;
    fetch_addr = a;
    @(posedge clock);
    #1;
    fetch_req = 1'b0;
    chk(flash_sel, a <= 16'h3FFF);
    chk(fetch_fault, a > 16'h3FFF);
    chk(fetch_pc, a);
    if (a <= 16'h3FFF)
      chk(flash_addr, a[13:0]);
    @(posedge clock);
    #1;
    chk(flash_sel, 1'b0);
    chk(fetch_fault, 1'b0);
    chk(fetch_pc, a);
  endtask
  task automatic t_reset();
    chk(fetch_pc, 16'h0000);
    chk(data_sel.target, mem_decode_pkg::tgt_none);
    chk(read_data, 8'h00);
    freq(16'h1234);
    rst = 1'b1;
    fetch_req = 1'b1;
    fetch_addr = 16'h2345;
    @(posedge clock);
    #1;
    rst = 1'b0;
    fetch_req = 1'b0;
    chk(fetch_pc, 16'h0000);
    chk(flash_sel, 1'b0);
    @(posedge clock);
    #1;
    chk(fetch_pc, 16'h0000);
  endtask
  task automatic t_program();
    freq(16'h0000);
    freq(16'h3FFF);
    freq(16'h4000);
  endtask
  task automatic t_internal();
    dreq(mem_decode_pkg::acc_direct, 16'h0005, 3'h0, mem_decode_pkg::tgt_bank, 16'h0005);
    dreq(mem_decode_pkg::acc_indirect, 16'h0010, 3'h0, mem_decode_pkg::tgt_bank, 16'h0010);
    dreq(mem_decode_pkg::acc_direct, 16'h0140, 3'h0, mem_decode_pkg::tgt_lowram, 16'h0040);
    dreq(mem_decode_pkg::acc_none, 16'h0040, 3'h0, mem_decode_pkg::tgt_none, 16'h0000);
    dreq(mem_decode_pkg::acc_direct, 16'h001F, 3'h0, mem_decode_pkg::tgt_bank, 16'h001F);
    dreq(mem_decode_pkg::acc_direct, 16'h0020, 3'h0, mem_decode_pkg::tgt_bitram, 16'h0020);
    dreq(mem_decode_pkg::acc_indirect, 16'h002F, 3'h0, mem_decode_pkg::tgt_bitram, 16'h002F);
    dreq(mem_decode_pkg::acc_direct, 16'h0030, 3'h0, mem_decode_pkg::tgt_lowram, 16'h0030);
    dreq(mem_decode_pkg::acc_indirect, 16'h007F, 3'h0, mem_decode_pkg::tgt_lowram, 16'h007F);
    dreq(mem_decode_pkg::acc_indirect, 16'h0080, 3'h0, mem_decode_pkg::tgt_upram, 16'h0080);
    dreq(mem_decode_pkg::acc_direct, 16'h0080, 3'h0, mem_decode_pkg::tgt_sfr, 16'h0080);
    dreq(mem_decode_pkg::acc_indirect, 16'h00FF, 3'h0, mem_decode_pkg::tgt_upram, 16'h00FF);
    dreq(mem_decode_pkg::acc_direct, 16'h00FF, 3'h0, mem_decode_pkg::tgt_sfr, 16'h00FF);
    dreq(mem_decode_pkg::acc_stack, 16'h0090, 3'h0, mem_decode_pkg::tgt_upram, 16'h0090);
  endtask
  task automatic t_bits();
    dreq(mem_decode_pkg::acc_bit, 16'h0013, 3'h3, mem_decode_pkg::tgt_bitram, 16'h0022);
    dreq(mem_decode_pkg::acc_bit, 16'h007F, 3'h7, mem_decode_pkg::tgt_bitram, 16'h002F);
    dreq(mem_decode_pkg::acc_bit, 16'h0088, 3'h0, mem_decode_pkg::tgt_sfr, 16'h0088);
    dreq(mem_decode_pkg::acc_bit, 16'h008F, 3'h7, mem_decode_pkg::tgt_sfr, 16'h0088);
  endtask
  task automatic t_external();
    dreq(mem_decode_pkg::acc_xmove, 16'h0040, 3'h0, mem_decode_pkg::tgt_external_data_ram, 16'h0040);
    dreq(mem_decode_pkg::acc_xmove, 16'h02FF, 3'h0, mem_decode_pkg::tgt_external_data_ram, 16'h02FF);
    dreq(mem_decode_pkg::acc_xmove, 16'h0300, 3'h0, mem_decode_pkg::tgt_xwin, 16'h0300);
    dreq(mem_decode_pkg::acc_xmove, 16'h4018, 3'h0, mem_decode_pkg::tgt_xwin, 16'h4018);
    dreq(mem_decode_pkg::acc_xmove, 16'h0400, 3'h0, mem_decode_pkg::tgt_none, 16'h0000);
    dreq(mem_decode_pkg::acc_xmove, 16'h4100, 3'h0, mem_decode_pkg::tgt_none, 16'h0000);
  endtask
  initial
  begin
    n_mismatch = 0;
    n_tests = 0;
    cycles = 0;
    rst = 1'b1;
    fetch_req = 1'b0;
    fetch_addr = 16'h0000;
    data_req = '0;
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    t_reset();
    t_program();
    t_internal();
    t_bits();
    t_external();
    final_report();
  end
endmodule
`default_nettype wire
